// File: bench/mem_side_model.sv
// Purpose: far-side memory model, raises read requests, measures gaps
// Assumes: request held until go, dropped on go
// Notes:   flags any strobe seen outside a go cycle
`timescale 1ns/1ps
`default_nettype none
module mem_side_model
   import area_idle_pkg::*;
(
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       arst_n_in,
   // bench control
   input  wire logic       start_in,
   input  wire logic       same_in,
   output var  logic       done_out,
   output var  logic [3:0] gap_out,
   output var  logic [3:0] lat_out,
   output var  logic       viol_out,
   // controller side
   input  wire logic       acc_go_in,
   input  wire logic       strobe_en_in,
   input  wire logic       idle_busy_in,
   output var  acc_req_t   acc_out
);
   logic [3:0] busy_r;
   logic [3:0] cyc_r;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         acc_out  <= '0;
         done_out <= 1'b0;
         gap_out  <= 4'h0;
         lat_out  <= 4'h0;
         viol_out <= 1'b0;
         busy_r   <= 4'h0;
         cyc_r    <= 4'h0;
      end else begin
         // strobes only with go, never in a gap
         if (strobe_en_in !== acc_go_in || (strobe_en_in && idle_busy_in)) begin
            viol_out <= 1'b1;
         end
         if (!acc_out.req && start_in) begin
            acc_out  <= '{req: 1'b1, same_area: same_in};
            done_out <= 1'b0;
            busy_r   <= 4'h0;
            cyc_r    <= 4'h0;
         end else if (acc_out.req) begin
            busy_r <= busy_r + {3'h0, idle_busy_in};
            cyc_r  <= cyc_r + 4'h1;
            // request held until go, then released at once
            if (acc_go_in) begin
               acc_out.req <= 1'b0;
               done_out    <= 1'b1;
               gap_out     <= busy_r;
               lat_out     <= cyc_r;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Purpose: register and idle-gap checks for the area control block
// Assumes: read data stand one cycle after the read strobe
// Notes:   gaps measured by the memory-side model
`timescale 1ns/1ps
`default_nettype none
`include "area_idle_defs.svh"
module testbench
   import area_idle_pkg::*;
;
   logic        mclk = 1'b0;
   logic        arst_n;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   acc_req_t    acc;
   logic        go, strobe, busy, illegal, start, same, done, viol;
   mem_kind_t   kind;
   logic [3:0]  gap, lat;
   int          err_total, n_compared, k;
   logic [3:0]  same_tab [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
   logic [3:0]  xarea_tab [4] = '{4'h1, 4'h2, 4'h3, 4'h5};
   always #2 mclk = ~mclk;
   area_idle_ctrl dut (.mclk_in(mclk), .arst_n_in(arst_n), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .acc_in(acc), .acc_go_out(go), .strobe_en_out(strobe), .idle_busy_out(busy),
      .mem_kind_out(kind), .kind_illegal_out(illegal));
   mem_side_model mem (.mclk_in(mclk), .arst_n_in(arst_n), .start_in(start),
      .same_in(same), .done_out(done), .gap_out(gap), .lat_out(lat), .viol_out(viol),
      .acc_go_in(go), .strobe_en_in(strobe), .idle_busy_in(busy), .acc_out(acc));
   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe, so sample there
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      check(rdata, exp);
   endtask
   task automatic access(input logic s, input logic [3:0] exp_gap);
      int i;
      @(posedge mclk);
      start <= 1'b1;
      same  <= s;
      @(posedge mclk);
      start <= 1'b0;
      // done of the previous access clears on this edge; look after it settles
      #1;
      for (i = 0; i < 40 && done !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      if (done !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      check({28'h0, gap}, {28'h0, exp_gap});
      check({28'h0, lat}, {28'h0, exp_gap + 4'h1});
   endtask
   initial begin
      {arst_n, addr, wdata, wr, rd, start, same} = '0;
      err_total  = 0;
      n_compared = 0;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      rd_chk(`CTL_OFFSET, 32'h001B0000);
      check({29'h0, kind}, 32'h0);
      access(1'b1, 4'h4);
      access(1'b0, 4'h5);
      wr_reg(`CTL_OFFSET, 32'hFFFFFFFF);
      rd_chk(`CTL_OFFSET, 32'h001B7000);
      wr_reg(8'h08, 32'h0);
      rd_chk(8'h08, 32'h0);
      rd_chk(`CTL_OFFSET, 32'h001B7000);
      for (k = 0; k < 7; k++) begin
         wr_reg(`CTL_OFFSET, 32'(k) << 12);
         rd_chk(`CTL_OFFSET, 32'(k) << 12);
         check({29'h0, kind}, (k < 5) ? 32'(k) : 32'h0);
         check({31'h0, illegal}, {31'h0, k > 4});
         rd_chk(`STS_OFFSET, {27'h0, k > 4, 4'h0});
      end
      for (k = 0; k < 4; k++) begin
         wr_reg(`CTL_OFFSET, (32'(k) << 19) | (32'(k) << 16));
         access(1'b1, same_tab[k]);
         access(1'b0, xarea_tab[k]);
      end
      check({31'h0, viol}, 32'h0);
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      rd_chk(`CTL_OFFSET, 32'h001B0000);
      print_verdict();
   end
endmodule
`default_nettype wire

// File: hdl/area_idle_ctrl.sv
// What this block does
// (R1) other-area read-read idle: 1,2,3,5 cycles
// (R2) other-area idle field at bits 20:19
// (R3) reserved bits 18 and 15 read zero
// (R4) same-area read-read idle field at bits 17:16
// (R5) same-area idle: 0,1,2,4 cycles
// (R6) same-area idle field resets to 11
// (R7) memory kind bits 14:12, reset normal
// (R8) memory kind decode; 101, 110, 111 flagged illegal
// (R9) strobes idle during gaps; access waits
//
// Purpose: area control register plus read-read idle gap sequencer
// Assumes: requester holds acc_in.req until acc_go_out pulses
// Notes:   offset 0x04 is a read-only status word
`timescale 1ns/1ps
`default_nettype none
`include "area_idle_defs.svh"

module area_idle_ctrl
   import area_idle_pkg::*;
(
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output var  logic [31:0] reg_rdata_out,
   // read access requests
   input  wire acc_req_t    acc_in,
   output var  logic        acc_go_out,
   output var  logic        strobe_en_out,
   output var  logic        idle_busy_out,
   // decoded memory kind
   output var  mem_kind_t   mem_kind_out,
   output var  logic        kind_illegal_out
);

   typedef enum logic [1:0] {
      ST_READY = 2'h0,
      ST_IDLE  = 2'h1,
      ST_GO    = 2'h2
   } seq_state_t;

   area_cfg_t   cfg_r, cfg_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   seq_state_t  st_r, st_nxt;
   logic [2:0]  cnt_r, cnt_nxt;
   logic        go_r, go_nxt;
   logic        strobe_r, strobe_nxt;
   logic        busy_r, busy_nxt;
   mem_kind_t   kind_r, kind_nxt;
   logic        ill_r, ill_nxt;
   logic [31:0] cfg_word;
   logic [2:0]  gap;

   always_comb begin
      cfg_word = 32'h0;                                 // (R3)
      cfg_word[`XAREA_HI_BIT:`XAREA_LO_BIT] = cfg_r.xarea_idle; // (R2)
      cfg_word[`SAME_HI_BIT:`SAME_LO_BIT]   = cfg_r.same_idle;  // (R4)
      cfg_word[`KIND_HI_BIT:`KIND_LO_BIT]   = cfg_r.kind;       // (R7)
   end

   // register write and read-back
   always_comb begin
      cfg_nxt   = cfg_r;
      rdata_nxt = 32'h0;
      if (reg_wr_in && reg_addr_in == `CTL_OFFSET) begin
         // reserved bits are not stored, so they always read back zero
         cfg_nxt.xarea_idle = reg_wdata_in[`XAREA_HI_BIT:`XAREA_LO_BIT]; // (R2)
         cfg_nxt.same_idle  = reg_wdata_in[`SAME_HI_BIT:`SAME_LO_BIT];   // (R4)
         cfg_nxt.kind       = reg_wdata_in[`KIND_HI_BIT:`KIND_LO_BIT];   // (R7)
      end
      if (reg_rd_in) begin
         if (reg_addr_in == `CTL_OFFSET) begin
            rdata_nxt = cfg_word; // (R3)
         end else if (reg_addr_in == `STS_OFFSET) begin
            rdata_nxt = {27'h0, ill_r, busy_r, cnt_r};
         end
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cfg_r   <= '{`XAREA_RST, `SAME_RST, `KIND_RST}; // (R6) (R7)
         rdata_r <= 32'h0;
      end else begin
         cfg_r   <= cfg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // memory kind decode
   always_comb begin
      ill_nxt = 1'b0;
      unique case (cfg_r.kind)
         3'h0: kind_nxt = KIND_NORMAL; // (R8)
         3'h1: kind_nxt = KIND_BROM;
         3'h2: kind_nxt = KIND_MUXIO;
         3'h3: kind_nxt = KIND_BSRAM;
         3'h4: kind_nxt = KIND_SDRAM;
         default: begin
            // illegal codes fall back to normal handling
            kind_nxt = KIND_NORMAL; // (R8)
            ill_nxt  = 1'b1;
         end
      endcase
   end

   // gap length for the waiting request
   always_comb begin
      if (acc_in.same_area) begin
         unique case (cfg_r.same_idle)
            2'h0: gap = 3'h0; // (R5)
            2'h1: gap = 3'h1;
            2'h2: gap = 3'h2;
            2'h3: gap = 3'h4;
         endcase
      end else begin
         unique case (cfg_r.xarea_idle)
            2'h0: gap = 3'h1; // (R1)
            2'h1: gap = 3'h2;
            2'h2: gap = 3'h3;
            2'h3: gap = 3'h5;
         endcase
      end
   end

   // idle sequencer: gap inserted before every read request, the first after reset included, except same-area requests with code 00
   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      go_nxt     = 1'b0;
      strobe_nxt = 1'b0;
      busy_nxt   = 1'b0;
      unique case (st_r)
         ST_READY: begin
            if (acc_in.req) begin
               if (gap == 3'h0) begin
                  st_nxt     = ST_GO;
                  go_nxt     = 1'b1;
                  strobe_nxt = 1'b1;
               end else begin
                  st_nxt   = ST_IDLE;
                  cnt_nxt  = gap - 3'h1;
                  busy_nxt = 1'b1; // (R9)
               end
            end
         end
         ST_IDLE: begin
            if (cnt_r == 3'h0) begin
               st_nxt     = ST_GO; // (R9)
               go_nxt     = 1'b1;
               strobe_nxt = 1'b1;
            end else begin
               cnt_nxt  = cnt_r - 3'h1;
               busy_nxt = 1'b1; // (R9)
            end
         end
         ST_GO: begin
            st_nxt = ST_READY;
         end
         default: st_nxt = ST_READY;
      endcase
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_r     <= ST_READY;
         cnt_r    <= 3'h0;
         go_r     <= 1'b0;
         strobe_r <= 1'b0;
         busy_r   <= 1'b0;
         kind_r   <= KIND_NORMAL;
         ill_r    <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         go_r     <= go_nxt;
         strobe_r <= strobe_nxt;
         busy_r   <= busy_nxt;
         kind_r   <= kind_nxt;
         ill_r    <= ill_nxt;
      end
   end

   assign reg_rdata_out    = rdata_r;
   assign acc_go_out       = go_r;
   assign strobe_en_out    = strobe_r;
   assign idle_busy_out    = busy_r;
   assign mem_kind_out     = kind_r;
   assign kind_illegal_out = ill_r;

   // checks
   a_resv_read_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (rdata_r & ~`WRITE_MASK) == 32'h0 || $past(reg_addr_in) != `CTL_OFFSET) // (R3)
      else $error("reserved bit read nonzero");
   a_idle_no_strobe: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      busy_r |-> !strobe_r && !go_r) // (R9)
      else $error("strobe during idle gap");
   a_same_four_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (st_r == ST_READY && acc_in.req && acc_in.same_area && cfg_r.same_idle == 2'h3)
      |=> busy_r [*4] ##1 go_r) // (R5)
      else $error("same-area gap not four");
   a_same_zero_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (st_r == ST_READY && acc_in.req && acc_in.same_area && cfg_r.same_idle == 2'h0)
      |=> go_r) // (R5)
      else $error("same-area zero gap wrong");
   a_xarea_five_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (st_r == ST_READY && acc_in.req && !acc_in.same_area && cfg_r.xarea_idle == 2'h3)
      |=> busy_r [*5] ##1 go_r) // (R1)
      else $error("other-area gap not five");
   a_xarea_one_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (st_r == ST_READY && acc_in.req && !acc_in.same_area && cfg_r.xarea_idle == 2'h0)
      |=> busy_r ##1 go_r) // (R1)
      else $error("other-area gap not one");
   a_kind_decode: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      ##1 (ill_r == ($past(cfg_r.kind) > 3'h4))) // (R8)
      else $error("kind illegal flag wrong");
   a_field_write: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `CTL_OFFSET) |=>
      cfg_r.xarea_idle == $past(reg_wdata_in[20:19])
      && cfg_r.same_idle == $past(reg_wdata_in[17:16])) // (R2)
      else $error("idle field write lost");
   a_kind_field: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `CTL_OFFSET) |=> cfg_r.kind == $past(reg_wdata_in[14:12])) // (R7)
      else $error("kind field write lost");
   a_reset_same: assert property (@(posedge mclk_in)
      $rose(arst_n_in) |-> cfg_r.same_idle == 2'h3) // (R6)
      else $error("same-area idle reset wrong");
   a_gap_ends: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      $rose(busy_r) |-> ##[1:6] go_r) // (R9)
      else $error("gap never ended");

   // remaining gap codes; the all-ones and zero cases sit above
   a_same_one_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R5)
      (st_r == ST_READY && acc_in.req && acc_in.same_area && cfg_r.same_idle == 2'h1)
      |=> busy_r ##1 go_r)
      else $error("same-area gap not one");
   a_same_two_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R5)
      (st_r == ST_READY && acc_in.req && acc_in.same_area && cfg_r.same_idle == 2'h2)
      |=> busy_r [*2] ##1 go_r)
      else $error("same-area gap not two");
   a_xarea_two_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R1)
      (st_r == ST_READY && acc_in.req && !acc_in.same_area && cfg_r.xarea_idle == 2'h1)
      |=> busy_r [*2] ##1 go_r)
      else $error("other-area gap not two");
   a_xarea_three_gap: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R1)
      (st_r == ST_READY && acc_in.req && !acc_in.same_area && cfg_r.xarea_idle == 2'h2)
      |=> busy_r [*3] ##1 go_r)
      else $error("other-area gap not three");

   // sequencer shape
   a_go_after_idle: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R9)
      $fell(busy_r) |-> go_r)
      else $error("gap ended without go");
   a_go_one_cycle: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R9)
      go_r |=> !go_r && st_r == ST_READY)
      else $error("go not a single pulse");
   a_busy_in_idle: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R9)
      busy_r |-> st_r == ST_IDLE)
      else $error("busy outside idle state");
   a_cnt_bound: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R1)
      cnt_r <= 3'h4)
      else $error("idle countdown too large");

   // register side
   a_kind_map: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R8)
      (cfg_r.kind <= 3'h4) |=> kind_r == $past(cfg_r.kind))
      else $error("legal kind code decoded wrong");
   a_sdram_code: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R8)
      (cfg_r.kind == 3'h4) |=> kind_r == KIND_SDRAM)
      else $error("sdram code decoded wrong");
   a_muxio_code: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R8)
      (cfg_r.kind == 3'h2) |=> kind_r == KIND_MUXIO)
      else $error("muxed io code decoded wrong");
   a_illegal_normal: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R8)
      ill_r |-> kind_r == KIND_NORMAL)
      else $error("illegal kind not normal");
   a_rdata_idle_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R3)
      !$past(reg_rd_in) |-> rdata_r == 32'h0)
      else $error("read data outside read slot");
   a_sts_resv_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R3)
      ($past(reg_rd_in) && $past(reg_addr_in) == `STS_OFFSET) |-> rdata_r[31:5] == 27'h0)
      else $error("status spare bits nonzero");
   a_cfg_hold: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // (R2)
      !(reg_wr_in && reg_addr_in == `CTL_OFFSET) |=> $stable(cfg_r))
      else $error("config changed without write");
   a_reset_kind: assert property (@(posedge mclk_in) // (R7)
      $rose(arst_n_in) |-> cfg_r.kind == 3'h0 && cfg_r.xarea_idle == 2'h3)
      else $error("kind or other-area reset wrong");

   c_same_gap: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
      acc_in.same_area && busy_r ##1 go_r);
   c_xarea_gap: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
      !acc_in.same_area && busy_r ##1 go_r);
   c_illegal: cover property (@(posedge mclk_in) disable iff (!arst_n_in) ill_r);
   c_sdram: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
      mem_kind_out == KIND_SDRAM);
   c_muxio: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
      mem_kind_out == KIND_MUXIO);

endmodule
`default_nettype wire

// File: hdl/area_idle_defs.svh
// Purpose: constants for the area idle and memory-type control block
// Assumes: 32-bit register word, control register at offset 0x0, status word at 0x04
// Notes:   definitions only
`ifndef AREA_IDLE_DEFS_SVH
`define AREA_IDLE_DEFS_SVH
`define CTL_OFFSET       8'h00
`define STS_OFFSET       8'h04
`define XAREA_HI_BIT     20
`define XAREA_LO_BIT     19
`define SAME_HI_BIT      17
`define SAME_LO_BIT      16
`define KIND_HI_BIT      14
`define KIND_LO_BIT      12
`define XAREA_RST        2'h3
`define SAME_RST         2'h3
`define KIND_RST         3'h0
`define WRITE_MASK       32'h001B7000
`endif

// File: hdl/area_idle_pkg.sv
// Purpose: types for the area idle and memory-type control block
// Assumes: nothing beyond the defs header
// Notes:   mem kind codes 101 to 111 are not legal settings
package area_idle_pkg;
   typedef enum logic [2:0] {
      KIND_NORMAL = 3'h0,
      KIND_BROM   = 3'h1,
      KIND_MUXIO  = 3'h2,
      KIND_BSRAM  = 3'h3,
      KIND_SDRAM  = 3'h4
   } mem_kind_t;

   typedef struct packed {
      logic [1:0] xarea_idle;
      logic [1:0] same_idle;
      logic [2:0] kind;
   } area_cfg_t;

   typedef struct packed {
      logic       req;
      logic       same_area;
   } acc_req_t;
endpackage
